// ### design/gigabit_serdes_lane_config_bank.sv
// Contract
// R1 - Software sets input hysteresis only after clearing offset compensation.
// R2 - Software sets signal-detect low-frequency mode in 100 Mbit fiber mode.
// R3 - Reserved fields are always written with their default values.
// R4 - Equalizer weighting resets to 2; codes 0 and 1 must not be used.
// R5 - Four-bit swing field, 50 mV steps, code 0 minimum, resets 0.
// R6 - De-emphasis bit inverts and delays second serializer tap one cycle.
// R7 - Idle bit inverts complementary first tap for output idle mode.
// R8 - Bit 0 enables alignment, bit 1 window, bit 2 wide window.
// R9 - Serializer bit 3 enables alignment hysteresis, resets 0.
// R10 - Facility loopback needs serializer phase alignment enabled and set up.
// R11 - Active-low lane system reset bit 31 resets 0, never self-clears.
// R12 - Bits 21 and 22 enable auto-squelch on clock buses A and B.
// R13 - Bits 19 and 20 put recovered clock onto buses A and B.
// R14 - Lane runs only while enable bit 18 is set; resets disabled.
// R15 - Bit 11 equipment loopback, bit 10 facility loopback, both reset off.
// R16 - PLL word bits 15:8 and sequencer enable bit 7, both reset zero.
// R17 - Divider: 0 undivided, 1 divide by 5, 2 divide by 4, 3 reserved.
// R18 - Misc bit 8 enables 100 Mbit fiber charge-pump/majority handling.
// R19 - Bits 5 and 4 let the PCS control receive and transmit power.
// R20 - Misc bit 3 inverts every received deserializer data bit.
// R21 - Miscellaneous register sits at offset 0x14 in its group.
// R22 - Misc bit 2 inverts every data bit sent toward the serializer.
// R23 - Misc bit 0 holds lane digital logic in reset; resets 0.
// R24 - Every field reads back last written value and drives it continuously.
`timescale 1ns/100ps
module gigabit_serdes_lane_config_bank #(
	parameter int DATA_W = 10
) (
	input wire logic clk_i,
	input wire logic reset_i,
	// analog group access
	input wire logic ana_sel_i,
	// digital group access
	input wire logic dig_sel_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o,
	output logic ack_o,
	// lane data path
	input wire logic [DATA_W-1:0] des_data_i,
	output logic [DATA_W-1:0] rx_data_o,
	input wire logic [DATA_W-1:0] tx_data_i,
	output logic [DATA_W-1:0] ser_data_o,
	input wire logic ser_d0b_i,
	input wire logic ser_d1_i,
	output logic ser_d0b_o,
	output logic ser_d1_o,
	input wire logic reco_clk_i,
	output logic reco_clk_o,
	// control settings to the lane macro
	output logic [31:0] ib_cfg_o,
	output logic [31:0] ob_cfg_o,
	output logic [31:0] ser_cfg_o,
	output logic [31:0] common_cfg_o,
	output logic [31:0] pll_cfg_o,
	output logic [31:0] misc_cfg_o,
	output logic [3:0] tx_swing_level_o,
	output logic phase_align_ena_o,
	output logic align_window_ena_o,
	output logic align_wide_window_o,
	output logic align_hysteresis_ena_o,
	output logic lane_system_reset_n_o,
	output logic lane_ena_o,
	output logic clkbus_a_lane_select_o,
	output logic clkbus_b_lane_select_o,
	output logic clkbus_a_squelch_ena_o,
	output logic clkbus_b_squelch_ena_o,
	output logic equipment_loopback_ena_o,
	output logic facility_loopback_ena_o,
	output logic [7:0] pll_sequencer_word_o,
	output logic pll_sequencer_ena_o,
	output logic fiber100_cpmd_ena_o,
	output logic rx_low_power_ena_o,
	output logic tx_low_power_ena_o,
	output logic lane_digital_reset_o
);
	import serdes_lane_cfg_pkg::*;

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// the inversion masks replicate one bit across the data word, so the
	// word needs at least one bit; wider words have no path in the lane macro
	if (DATA_W < 1 || DATA_W > 64) begin
		$error("DATA_W out of range");
	end

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [31:0] rx_input_buffer_cfg;
	logic [31:0] tx_output_buffer_cfg;
	logic [31:0] serializer_cfg;
	logic [31:0] lane_common_cfg;
	logic [31:0] lane_pll_cfg;
	logic [31:0] lane_misc_digital_cfg;
	logic d1_delayed;
	logic [2:0] div_cnt;
	logic reco_div;
	// divider code as seen in the recovered clock domain
	logic [1:0] code_meta;
	logic [1:0] code_sync;
	logic [1:0] code_hold;
	logic [1:0] div_code;

	// ---------------------------------------------------------------
	// register access
	// ---------------------------------------------------------------
	// masked write merge keeps unimplemented bits at zero
	function automatic logic [31:0] wmerge(input logic [31:0] d, input logic [31:0] m);
		wmerge = d & m;
	endfunction

	function automatic logic ana_hit(input logic sel, input logic w, input logic [7:0] a, input logic [7:0] off);
		ana_hit = sel && w && (a == off);
	endfunction

	// analog group writes; reserved fields stored as written
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_input_buffer_cfg <= rx_input_buffer_cfg_rst; // R4
			tx_output_buffer_cfg <= tx_output_buffer_cfg_rst; // R5
			serializer_cfg <= serializer_cfg_rst; // R9
			lane_common_cfg <= lane_common_cfg_rst; // R11
			lane_pll_cfg <= lane_pll_cfg_rst; // R16
		end else begin
			// input buffer: hysteresis and offset compensation are not interlocked here
			if (ana_hit(ana_sel_i, wr_i, addr_i, rx_input_buffer_cfg_off)) begin
				rx_input_buffer_cfg <= wmerge(wdata_i, rx_input_buffer_cfg_mask); // R24
			end
			// output buffer: slope, swing and common mode
			if (ana_hit(ana_sel_i, wr_i, addr_i, tx_output_buffer_cfg_off)) begin
				tx_output_buffer_cfg <= wmerge(wdata_i, tx_output_buffer_cfg_mask); // R24
			end
			// serializer: taps and phase alignment
			if (ana_hit(ana_sel_i, wr_i, addr_i, serializer_cfg_off)) begin
				serializer_cfg <= wmerge(wdata_i, serializer_cfg_mask); // R24
			end
			// common: lane reset only changes on a write, never by itself
			if (ana_hit(ana_sel_i, wr_i, addr_i, lane_common_cfg_off)) begin
				lane_common_cfg <= wmerge(wdata_i, lane_common_cfg_mask); // R11
			end
			// pll sequencer word and enable
			if (ana_hit(ana_sel_i, wr_i, addr_i, lane_pll_cfg_off)) begin
				lane_pll_cfg <= wmerge(wdata_i, lane_pll_cfg_mask); // R16
			end
		end
	end

	// digital group write
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lane_misc_digital_cfg <= lane_misc_digital_cfg_rst; // R23
		end else if (ana_hit(dig_sel_i, wr_i, addr_i, lane_misc_digital_cfg_off)) begin
			lane_misc_digital_cfg <= wmerge(wdata_i, lane_misc_digital_cfg_mask); // R21
		end
	end

	// read data and acknowledge, one cycle after the access
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0000_0000;
			ack_o <= 1'b0;
		end else begin
			// every selected cycle is answered, mapped or not
			ack_o <= ana_sel_i | dig_sel_i;
			// read data idles at zero between accesses
			rdata_o <= 32'h0000_0000;
			// with both selects high the digital register wins at its offset
			if (dig_sel_i && addr_i == lane_misc_digital_cfg_off) begin
				rdata_o <= lane_misc_digital_cfg; // R24
			end else if (ana_sel_i) begin
				case (addr_i)
					rx_input_buffer_cfg_off: rdata_o <= rx_input_buffer_cfg;
					tx_output_buffer_cfg_off: rdata_o <= tx_output_buffer_cfg;
					serializer_cfg_off: rdata_o <= serializer_cfg;
					lane_common_cfg_off: rdata_o <= lane_common_cfg;
					lane_pll_cfg_off: rdata_o <= lane_pll_cfg;
					default: rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// serializer taps and data inversion
	// ---------------------------------------------------------------
	// de-emphasis tap delay, idle inversion, data path inversion
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			d1_delayed <= 1'b0;
			ser_d1_o <= 1'b0;
			ser_d0b_o <= 1'b0;
			rx_data_o <= '0;
			ser_data_o <= '0;
		end else begin
			// inverted copy of the second tap, one cycle behind
			d1_delayed <= ~ser_d1_i;
			ser_d1_o <= serializer_cfg[ser_deemphasis_tap_bit] ? d1_delayed : ser_d1_i; // R6
			ser_d0b_o <= ser_d0b_i ^ serializer_cfg[invert_a_bit]; // R7
			// receive and transmit words pass through one register stage
			rx_data_o <= des_data_i ^ {DATA_W{lane_misc_digital_cfg[misc_rxinv_bit]}}; // R20
			ser_data_o <= tx_data_i ^ {DATA_W{lane_misc_digital_cfg[misc_txinv_bit]}}; // R22
		end
	end

	// ---------------------------------------------------------------
	// recovered clock divider
	// ---------------------------------------------------------------
	// two-flop synchroniser for the divider code; a new code is adopted only
	// once two samples agree, so a pair of bits caught mid-change never
	// reaches the counter or the output mux
	always_ff @(posedge reco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			code_meta <= div_none;
			code_sync <= div_none;
			code_hold <= div_none;
			div_code <= div_none;
		end else begin
			code_meta <= lane_misc_digital_cfg[misc_div_lsb +: 2];
			code_sync <= code_meta;
			code_hold <= code_sync;
			if (code_sync == code_hold) begin
				div_code <= code_hold; // R17
			end
		end
	end

	// divide by 5 or 4, output high for two input cycles of each period
	always_ff @(posedge reco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt <= 3'h0;
			reco_div <= 1'b0;
		end else begin
			case (div_code)
				div_by5: begin
					div_cnt <= (div_cnt >= div5_last) ? 3'h0 : div_cnt + 3'h1; // R17
					reco_div <= (div_cnt < 3'h2);
				end
				div_by4: begin
					div_cnt <= (div_cnt >= div4_last) ? 3'h0 : div_cnt + 3'h1; // R17
					reco_div <= (div_cnt < 3'h2);
				end
				default: begin
					div_cnt <= 3'h0;
					reco_div <= 1'b0;
				end
			endcase
		end
	end

	// undivided path for code 0, reserved code 3 gives no clock
	always_comb begin
		case (div_code)
			div_none: reco_clk_o = reco_clk_i; // R17
			div_by5, div_by4: reco_clk_o = reco_div;
			default: reco_clk_o = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// field outputs to the lane macro
	// ---------------------------------------------------------------
	// whole register images to the lane macro
	assign ib_cfg_o = rx_input_buffer_cfg; // R24
	assign ob_cfg_o = tx_output_buffer_cfg;
	assign ser_cfg_o = serializer_cfg;
	assign common_cfg_o = lane_common_cfg;
	assign pll_cfg_o = lane_pll_cfg;
	assign misc_cfg_o = lane_misc_digital_cfg;

	// output buffer swing, one step per code
	assign tx_swing_level_o = tx_output_buffer_cfg[ob_swing_lsb +: 4]; // R5

	// serializer phase alignment controls
	assign phase_align_ena_o = serializer_cfg[ser_ali_bit]; // R8
	assign align_window_ena_o = serializer_cfg[ser_win_bit]; // R8
	assign align_wide_window_o = serializer_cfg[ser_wide_bit]; // R8
	assign align_hysteresis_ena_o = serializer_cfg[ser_hys_bit]; // R9

	// lane reset, lane enable and clock bus controls
	assign lane_system_reset_n_o = lane_common_cfg[cm_sysrst_bit]; // R11
	assign lane_ena_o = lane_common_cfg[cm_lane_bit]; // R14
	assign clkbus_a_lane_select_o = lane_common_cfg[cm_sel_a_bit]; // R13
	assign clkbus_b_lane_select_o = lane_common_cfg[cm_sel_b_bit]; // R13
	assign clkbus_a_squelch_ena_o = lane_common_cfg[cm_sq_a_bit]; // R12
	assign clkbus_b_squelch_ena_o = lane_common_cfg[cm_sq_b_bit]; // R12

	// loopbacks; facility loopback needs alignment set up by software first
	assign equipment_loopback_ena_o = lane_common_cfg[cm_eloop_bit]; // R15
	assign facility_loopback_ena_o = lane_common_cfg[cm_floop_bit]; // R15

	// pll sequencer control word and enable
	assign pll_sequencer_word_o = lane_pll_cfg[pll_word_lsb +: 8]; // R16
	assign pll_sequencer_ena_o = lane_pll_cfg[pll_ena_bit]; // R16

	// miscellaneous settings to the deserializer, pcs and lane digital logic
	assign fiber100_cpmd_ena_o = lane_misc_digital_cfg[misc_fx_bit]; // R18
	assign rx_low_power_ena_o = lane_misc_digital_cfg[misc_rxlp_bit]; // R19
	assign tx_low_power_ena_o = lane_misc_digital_cfg[misc_txlp_bit]; // R19
	assign lane_digital_reset_o = lane_misc_digital_cfg[misc_lrst_bit]; // R23

endmodule

// ### design/serdes_lane_cfg_pkg.sv
package serdes_lane_cfg_pkg;

	// ---------------------------------------------------------------
	// register offsets within their groups (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] rx_input_buffer_cfg_off = 8'h04;
	localparam logic [7:0] tx_output_buffer_cfg_off = 8'h08;
	localparam logic [7:0] serializer_cfg_off = 8'h0C;
	localparam logic [7:0] lane_common_cfg_off = 8'h10;
	localparam logic [7:0] lane_pll_cfg_off = 8'h14;
	localparam logic [7:0] lane_misc_digital_cfg_off = 8'h14;

	// ---------------------------------------------------------------
	// writable bit masks per register
	// ---------------------------------------------------------------
	localparam logic [31:0] rx_input_buffer_cfg_mask = 32'h0F38_7FFF;
	localparam logic [31:0] tx_output_buffer_cfg_mask = 32'h0007_FCFF;
	localparam logic [31:0] serializer_cfg_mask = 32'h0000_030F;
	localparam logic [31:0] lane_common_cfg_mask = 32'h807C_0C01;
	localparam logic [31:0] lane_pll_cfg_mask = 32'h0020_FF80;
	localparam logic [31:0] lane_misc_digital_cfg_mask = 32'h0003_013D;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [31:0] rx_input_buffer_cfg_rst = 32'h0100_228B;
	localparam logic [31:0] tx_output_buffer_cfg_rst = 32'h0006_0841;
	localparam logic [31:0] serializer_cfg_rst = 32'h0000_0000;
	localparam logic [31:0] lane_common_cfg_rst = 32'h0000_0001;
	localparam logic [31:0] lane_pll_cfg_rst = 32'h0020_0000;
	localparam logic [31:0] lane_misc_digital_cfg_rst = 32'h0000_0000;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ib_lowfreq_bit = 27;
	localparam int ib_hyst_bit = 10;
	localparam int ib_offset_bit = 9;
	localparam int ib_eq_lsb = 6;
	localparam int ob_swing_lsb = 13;
	localparam int invert_a_bit = 9;
	localparam int ser_deemphasis_tap_bit = 8;
	localparam int ser_hys_bit = 3;
	localparam int ser_wide_bit = 2;
	localparam int ser_win_bit = 1;
	localparam int ser_ali_bit = 0;
	localparam int cm_sysrst_bit = 31;
	localparam int cm_sq_b_bit = 22;
	localparam int cm_sq_a_bit = 21;
	localparam int cm_sel_b_bit = 20;
	localparam int cm_sel_a_bit = 19;
	localparam int cm_lane_bit = 18;
	localparam int cm_eloop_bit = 11;
	localparam int cm_floop_bit = 10;
	localparam int pll_word_lsb = 8;
	localparam int pll_ena_bit = 7;
	localparam int misc_div_lsb = 16;
	localparam int misc_fx_bit = 8;
	localparam int misc_rxlp_bit = 5;
	localparam int misc_txlp_bit = 4;
	localparam int misc_rxinv_bit = 3;
	localparam int misc_txinv_bit = 2;
	localparam int misc_lrst_bit = 0;

	// recovered clock divider codes
	localparam logic [1:0] div_none = 2'h0;
	localparam logic [1:0] div_by5 = 2'h1;
	localparam logic [1:0] div_by4 = 2'h2;
	localparam logic [2:0] div5_last = 3'h4;
	localparam logic [2:0] div4_last = 3'h3;

endpackage

// ### verif/lane_cfg_props.sv
`timescale 1ns/100ps
// ------
// lane config bank checker
// ------
module lane_cfg_props
	import serdes_lane_cfg_pkg::*;
#(
	parameter int DATA_W = 10
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ana_sel_i,
	input wire logic dig_sel_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic ack_o,
	input wire logic [DATA_W-1:0] des_data_i,
	input wire logic [DATA_W-1:0] rx_data_o,
	input wire logic [DATA_W-1:0] tx_data_i,
	input wire logic [DATA_W-1:0] ser_data_o,
	input wire logic ser_d0b_i,
	input wire logic ser_d1_i,
	input wire logic ser_d0b_o,
	input wire logic ser_d1_o,
	input wire logic reco_clk_i,
	input wire logic reco_clk_o,
	input wire logic [31:0] ser_cfg_o,
	input wire logic [31:0] common_cfg_o,
	input wire logic [31:0] misc_cfg_o,
	input wire logic lane_system_reset_n_o,
	input wire logic lane_ena_o
);
	logic [1:0] live;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// counts edges since reset so $past only sees settled history
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			live <= 2'h0;
		end else begin
			live <= {live[0], 1'h1};
		end
	end
	// access handshake and register behaviour
	a_ack_on_select: assert property ((ana_sel_i || dig_sel_i) |=> ack_o) else $error("ack missing");
	a_ack_no_select: assert property (!(ana_sel_i || dig_sel_i) |=> !ack_o) else $error("stray ack");
	a_ser_write_lands: assert property (ana_sel_i && wr_i && addr_i == serializer_cfg_off
		|=> ser_cfg_o == ($past(wdata_i) & serializer_cfg_mask)) else $error("serializer write lost");
	a_sysrst_holds: assert property (common_cfg_o[31] && !(ana_sel_i && wr_i) |=> common_cfg_o[31]) else $error("self clear");
	a_lane_fields: assert property (ana_sel_i && wr_i && addr_i == lane_common_cfg_off
		|=> lane_ena_o == $past(wdata_i[18]) && lane_system_reset_n_o == $past(wdata_i[31]))
		else $error("lane field mismatch");
	// serializer taps
	a_idle_invert: assert property (live[0] |-> ser_d0b_o == ($past(ser_d0b_i) ^ $past(ser_cfg_o[9])))
		else $error("idle tap wrong");
	a_deemph_delay: assert property (live[1] && $past(ser_cfg_o[8]) && $past(ser_cfg_o[8], 2)
		|-> ser_d1_o == !$past(ser_d1_i, 2)) else $error("deemphasis tap wrong");
	a_d1_direct: assert property (live[0] && !$past(ser_cfg_o[8]) |-> ser_d1_o == $past(ser_d1_i)) else $error("tap wrong");
	// data inversion and clock bypass
	a_rx_invert: assert property (live[0] |-> rx_data_o == ($past(des_data_i) ^ {DATA_W{$past(misc_cfg_o[3])}}))
		else $error("rx data wrong");
	a_tx_invert: assert property (live[0] |-> ser_data_o == ($past(tx_data_i) ^ {DATA_W{$past(misc_cfg_o[2])}}))
		else $error("tx data wrong");
	a_reco_bypass: assert property ((misc_cfg_o[17:16] == div_none) [*8] |-> reco_clk_o == reco_clk_i)
		else $error("bypass");
endmodule

bind gigabit_serdes_lane_config_bank lane_cfg_props #(.DATA_W(DATA_W)) u_props (.*);

// ### verif/lane_macro_model.sv
`timescale 1ns/100ps
// ------
// lane macro and pcs stand-in
// ------
module lane_macro_model #(
	parameter int DATA_W = 10
) (
	input wire logic clk_i,
	output logic [DATA_W-1:0] des_data_o,
	output logic [DATA_W-1:0] tx_data_o,
	output logic d0b_o,
	output logic d1_o,
	output logic reco_clk_o
);
	logic [DATA_W-1:0] cnt = '0;
	// pattern moves every cycle so a held or stale value shows up
	always @(posedge clk_i) begin
		cnt <= #1 {cnt[DATA_W-2:0], ~cnt[DATA_W-1] ^ cnt[2]};
	end
	// data and tap outputs from the pattern
	assign des_data_o = cnt;
	assign tx_data_o = ~{cnt[3:0], cnt[DATA_W-1:4]};
	assign d0b_o = cnt[1];
	assign d1_o = cnt[0];
	// recovered clock runs free, unrelated to the bank clock
	initial reco_clk_o = 1'h0;
	always #35 reco_clk_o = ~reco_clk_o;
endmodule

// ### verif/gigabit_serdes_lane_config_bank_tb.sv
`timescale 1ns/100ps
// ------
// lane config bank testbench
// ------
module gigabit_serdes_lane_config_bank_tb;
	import serdes_lane_cfg_pkg::*;
	localparam int DW = 10;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic ana_sel_i = 1'h0;
	logic dig_sel_i = 1'h0;
	logic wr_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o, ib_cfg_o, ob_cfg_o, ser_cfg_o, common_cfg_o, pll_cfg_o, misc_cfg_o, junk;
	logic [DW-1:0] des_data_i, rx_data_o, tx_data_i, ser_data_o;
	logic ack_o, ser_d0b_i, ser_d1_i, ser_d0b_o, ser_d1_o, reco_clk_i, reco_clk_o;
	logic [3:0] tx_swing_level_o;
	logic [7:0] pll_sequencer_word_o;
	logic phase_align_ena_o, align_window_ena_o, align_wide_window_o, align_hysteresis_ena_o, lane_system_reset_n_o;
	logic lane_ena_o, clkbus_a_lane_select_o, clkbus_b_lane_select_o, clkbus_a_squelch_ena_o, clkbus_b_squelch_ena_o;
	logic equipment_loopback_ena_o, facility_loopback_ena_o, pll_sequencer_ena_o, fiber100_cpmd_ena_o;
	logic rx_low_power_ena_o, tx_low_power_ena_o, lane_digital_reset_o;
	int mismatches = 0;
	int samples_checked = 0;
	int edges = 0;
	logic [31:0] rsts [6] = '{32'h0100_228B, 32'h0006_0841, 32'h0, 32'h1, 32'h0020_0000, 32'h0};
	logic [31:0] vals [6] = '{32'h0938_5DFB, 32'h0001_E871, 32'h0000_030F, 32'h807C_0C01, 32'h0020_FF80, 32'h0002_013D};
	logic [7:0] offs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h14};
	// every single-field control output side by side
	wire [28:0] flags = {tx_swing_level_o, pll_sequencer_word_o, phase_align_ena_o, align_window_ena_o,
		align_wide_window_o, align_hysteresis_ena_o, lane_system_reset_n_o, lane_ena_o, clkbus_a_lane_select_o,
		clkbus_b_lane_select_o, clkbus_a_squelch_ena_o, clkbus_b_squelch_ena_o, equipment_loopback_ena_o,
		facility_loopback_ena_o, pll_sequencer_ena_o, fiber100_cpmd_ena_o, rx_low_power_ena_o, tx_low_power_ena_o,
		lane_digital_reset_o};
	// whole register images, input buffer register in the top word
	wire [191:0] cfgs = {ib_cfg_o, ob_cfg_o, ser_cfg_o, common_cfg_o, pll_cfg_o, misc_cfg_o};

	gigabit_serdes_lane_config_bank #(.DATA_W(DW)) DUT (.*);
	lane_macro_model #(.DATA_W(DW)) u_far (.clk_i(clk_i), .des_data_o(des_data_i), .tx_data_o(tx_data_i),
		.d0b_o(ser_d0b_i), .d1_o(ser_d1_i), .reco_clk_o(reco_clk_i));

	// bank clock, 50 ns period
	always #25 clk_i = ~clk_i;
	// counts divided recovered clock edges
	always @(posedge reco_clk_o) edges++;

	// ------
	// shared tasks
	// ------
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic xfer(input logic a, input logic d, input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] got);
		@(posedge clk_i) #1;
		ana_sel_i = a;
		dig_sel_i = d;
		wr_i = w;
		addr_i = ad;
		wdata_i = wd;
		@(posedge clk_i) #1;
		ana_sel_i = 1'h0;
		dig_sel_i = 1'h0;
		wr_i = 1'h0;
		check(32'(ack_o), 32'h1);
		got = rdata_o;
	endtask
	task automatic rd(input logic a, input logic [7:0] ad, input logic [31:0] want);
		logic [31:0] got;
		xfer(a, !a, 1'h0, ad, 32'h0, got);
		check(got, want);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------
	// scenarios
	// ------
	task automatic t_defaults;
		for (int i = 0; i < 6; i++) begin
			rd(i < 5, offs[i], rsts[i]);
			check(cfgs[191 - 32 * i -: 32], rsts[i]);
		end
		check(32'(flags), 32'h0);
		$display("test defaults done");
	endtask
	task automatic t_rw;
		xfer(1'h1, 1'h0, 1'h1, 8'h04, 32'h0100_208B, junk);
		for (int i = 0; i < 6; i++) begin
			xfer(i < 5, i == 5, 1'h1, offs[i], vals[i], junk);
		end
		for (int i = 0; i < 6; i++) begin
			rd(i < 5, offs[i], vals[i]);
			check(cfgs[191 - 32 * i -: 32], vals[i]);
		end
		check(32'(flags), 32'h1FFF_FFFF);
		repeat (12) @(posedge clk_i);
		check(32'(flags), 32'h1FFF_FFFF);
		$display("test write readback done");
	endtask
	task automatic t_unmapped;
		xfer(1'h1, 1'h0, 1'h1, 8'h00, 32'hFFFF_FFFF, junk);
		xfer(1'h0, 1'h1, 1'h1, 8'h10, 32'hFFFF_FFFF, junk);
		rd(1'h1, 8'h00, 32'h0);
		rd(1'h1, 8'h18, 32'h0);
		rd(1'h0, 8'h04, 32'h0);
		rd(1'h1, 8'h10, vals[3]);
		rd(1'h0, 8'h14, vals[5]);
		$display("test unmapped done");
	endtask
	task automatic t_divider;
		int want [4] = '{40, 8, 10, 0};
		for (int c = 0; c < 4; c++) begin
			xfer(1'h0, 1'h1, 1'h1, 8'h14, {14'h0, 2'(c), 16'h0}, junk);
			repeat (6) @(posedge reco_clk_i);
			edges = 0;
			repeat (40) @(posedge reco_clk_i);
			check(32'(edges >= want[c] - 1 && edges <= want[c] + 1), 32'h1);
		end
		$display("test divider done");
	endtask

	// main sequence with a second reset in mid-run
	initial begin
		repeat (6) @(posedge clk_i);
		#1 reset_i = 1'h0;
		t_defaults();
		t_rw();
		t_unmapped();
		t_divider();
		@(posedge clk_i) #1 reset_i = 1'h1;
		@(posedge clk_i) #1 reset_i = 1'h0;
		t_defaults();
		tally_and_finish();
	end
	// cuts a hung run short
	initial begin
		#1000000;
		mismatches++;
		tally_and_finish();
	end
endmodule
